// ===== common/thc_pkg.sv
// constants shared by the transmit and hardware configuration register bank
// assumes a 50 MHz system clock and an ahb-lite master with word accesses
package thc_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_TRANSMIT_CONFIGURATION = 8'h70;
    localparam logic [7:0] OFF_HARDWARE_CONFIGURATION = 8'h74;
    localparam int ADDR_DEC_W = 8;

    // transmit configuration fields
    localparam int TXC_STATUS_FLUSH_BIT = 15;
    localparam int TXC_DATA_FLUSH_BIT = 14;
    localparam int TXC_ALLOW_BIT = 2;
    localparam int TXC_ENABLE_BIT = 1;
    localparam int TXC_STOP_BIT = 0;

    // hardware configuration fields
    localparam int HWC_PORT_ORDER_BIT = 29;
    localparam int HWC_DIRECT_ORDER_BIT = 28;
    localparam int HWC_STRAP_BIT = 24;
    localparam int HWC_MWO_BIT = 20;
    localparam int HWC_ALLOC_LSB = 16;
    localparam int HWC_ALLOC_W = 4;
    localparam int HWC_TIMEOUT_BIT = 1;
    localparam int HWC_SOFTWARE_RESET_BIT = 0;
    localparam logic [3:0] ALLOC_RESET = 4'h5;

    // queue memory split, all byte counts
    localparam int SIZE_W = 15;
    localparam logic [14:0] KB_BYTES = 15'h0400;
    localparam logic [14:0] TOTAL_BYTES = 15'h4000;
    localparam logic [14:0] TX_STATUS_BYTES = 15'h0200;
    localparam int RX_STATUS_SHIFT = 4;

    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // soft reset timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SOFTWARE_RESET_HOLD_NS = 200;
    localparam int SOFTWARE_RESET_TIMEOUT_NS = 40000;
    localparam int SOFTWARE_RESET_HOLD_CYC =
        (SOFTWARE_RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SOFTWARE_RESET_TIMEOUT_CYC = SOFTWARE_RESET_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int SOFTWARE_RESET_CNT_W = 12;

    // soft reset sequencer states, gray along idle-wait-done
    typedef enum logic [1:0] {
        THC_SR_IDLE = 2'b00,
        THC_SR_WAIT = 2'b01,
        THC_SR_DONE = 2'b11,
        THC_SR_TOUT = 2'b10
    } thc_sr_state_t;

endpackage

// ===== src/thc_regs.sv
// transmit and hardware configuration register bank, ahb-lite slave
// assumes one ahb-lite master, word accesses, and that the transmitter
// reports frame activity and status queue fullness synchronous to hclk
//
// What this block does
// - writing one to status flush empties tx status queue, bit self-clears
// - writing one to data flush discards pending tx data, bit self-clears
// - allow-bit zero pauses tx on full status queue, one keeps sending
// - status-full interrupt source ignores the allow bit entirely
// - enable bit one lets the transmitter send queued data, resets zero
// - hardware clears the enable bit once a stop has halted transmitter
// - stop lets the current frame finish, then self-clears when halted
// - host writes to the stop bit are ignored while it reads one
// - port byte order bit selects little or big endian for port path
// - direct path byte order bit selects endianness for direct path
// - both byte order bits survive a software reset unchanged
// - read-only strap bit shows the sampled crossover strap level
// - must-write-one bit resets zero; host writes one for operation
// - allocation field sets tx size in 1KB steps; 512 bytes go to status
// - receive queues share 16KB minus the transmit allocation
// - receive status gets one sixteenth of receive space, data the rest
// - writing one to reset bit starts soft reset, clears on completion
// - soft reset without phy clocks times out and sets timeout bit
`timescale 1ns/10ps
module thc_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic tx_frame_busy,
    input wire logic tx_status_full,
    input wire logic phy_clocks_running,
    input wire logic crossover_strap,
    output logic tx_start_ok,
    output logic tx_status_full_event,
    output logic tx_status_flush,
    output logic tx_data_flush,
    output logic port_byte_order,
    output logic direct_path_byte_order,
    output logic device_operational,
    output logic soft_reset_active,
    output logic [thc_pkg::SIZE_W-1:0] tx_data_bytes,
    output logic [thc_pkg::SIZE_W-1:0] tx_status_bytes,
    output logic [thc_pkg::SIZE_W-1:0] rx_data_bytes,
    output logic [thc_pkg::SIZE_W-1:0] rx_status_bytes
);
    import thc_pkg::*;

    // kilobyte count to bytes, used for the allocation arithmetic
    // fourteen kilobytes, the legal top, fits in 15 bits
    function automatic logic [SIZE_W-1:0] kb_to_bytes(
        input logic [HWC_ALLOC_W-1:0] kb
    );
        kb_to_bytes = SIZE_W'({11'h000, kb} * KB_BYTES);
    endfunction

    // word select on the decoded low address byte
    function automatic logic hit(
        input logic [ADDR_DEC_W-1:0] addr,
        input logic [ADDR_DEC_W-1:0] off
    );
        hit = (addr[ADDR_DEC_W-1:2] == off[ADDR_DEC_W-1:2]);
    endfunction

    // ---------------- bus phase tracking ----------------
    logic wr_pend_ff, nxt_wr_pend;
    logic rd_pend_ff, nxt_rd_pend;
    logic [ADDR_DEC_W-1:0] addr_ff, nxt_addr;
    logic hreadyout_ff, nxt_hreadyout;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic hresp_ff;

    // configuration state
    // fields hold until written or reset, unless halt, soft reset, timeout or strap sampling updates them; flush bits pulse
    logic stop_ff, nxt_stop;
    logic enable_ff, nxt_enable;
    logic allow_ff, nxt_allow;
    logic st_flush_ff, nxt_st_flush;
    logic dt_flush_ff, nxt_dt_flush;
    logic port_order_ff, nxt_port_order;
    logic direct_order_ff, nxt_direct_order;
    logic mwo_ff, nxt_mwo;
    logic [HWC_ALLOC_W-1:0] alloc_ff, nxt_alloc;
    logic timeout_ff, nxt_timeout;
    logic strap_ff, nxt_strap;
    logic strap_pend_ff, nxt_strap_pend;

    // registered side outputs
    logic tx_start_ok_ff, full_event_ff, sr_active_ff;
    logic [SIZE_W-1:0] txd_ff, txs_ff, rxd_ff, rxs_ff;

    logic sr_busy, sr_done, sr_timeout;

    // address phase accepted when selected, ready and a real transfer
    wire accept = hsel && hready && htrans[1];
    wire accept_rd = accept && !hwrite;
    wire accept_wr = accept && hwrite;

    // data phase write strobes per register
    // reads decode the held address; rd_pend_ff gates the load
    wire wr_txc = wr_pend_ff && hit(addr_ff, OFF_TRANSMIT_CONFIGURATION);
    wire wr_hwc = wr_pend_ff && hit(addr_ff, OFF_HARDWARE_CONFIGURATION);
    wire rd_txc = hit(addr_ff, OFF_TRANSMIT_CONFIGURATION);
    wire rd_hwc = hit(addr_ff, OFF_HARDWARE_CONFIGURATION);

    // soft reset start: a second request while busy is ignored
    wire sr_start = wr_hwc && hwdata[HWC_SOFTWARE_RESET_BIT] && !sr_busy;
    wire sr_bit = sr_busy || sr_start;

    // halted once a stop is pending and no frame is on the wire; the
    // grant lags the stop bit a cycle, so a frame may still start then
    wire halted = stop_ff && !tx_frame_busy && !tx_start_ok_ff;

    // transmit pauses on a full status queue unless overrun allowed
    wire start_gate = enable_ff && !stop_ff &&
        (allow_ff || !tx_status_full);

    // allocation split of the shared queue memory
    wire [SIZE_W-1:0] tx_total = kb_to_bytes(alloc_ff);
    wire [SIZE_W-1:0] rx_total = TOTAL_BYTES - tx_total;
    wire [SIZE_W-1:0] rx_stat = rx_total >> RX_STATUS_SHIFT;

    // read views; reserved bits are zero by construction
    // flush bits read one only in their pulse cycle
    wire [31:0] txc_view = (32'(st_flush_ff) << TXC_STATUS_FLUSH_BIT) |
        (32'(dt_flush_ff) << TXC_DATA_FLUSH_BIT) |
        (32'(allow_ff) << TXC_ALLOW_BIT) |
        (32'(enable_ff) << TXC_ENABLE_BIT) |
        (32'(stop_ff) << TXC_STOP_BIT);
    wire [31:0] hwc_view = (32'(port_order_ff) << HWC_PORT_ORDER_BIT) |
        (32'(direct_order_ff) << HWC_DIRECT_ORDER_BIT) |
        (32'(strap_ff) << HWC_STRAP_BIT) |
        (32'(mwo_ff) << HWC_MWO_BIT) |
        (32'(alloc_ff) << HWC_ALLOC_LSB) |
        (32'(timeout_ff) << HWC_TIMEOUT_BIT) |
        (32'(sr_busy) << HWC_SOFTWARE_RESET_BIT);
    wire [31:0] rd_view = rd_txc ? txc_view :
        (rd_hwc ? hwc_view : DATA_ZERO);

    // bus phase next state; reads take one wait state so that a write
    // still in its data phase has landed before the read data is picked
    always_comb begin
        nxt_wr_pend = accept_wr;
        nxt_rd_pend = accept_rd;
        nxt_addr = accept ? haddr[ADDR_DEC_W-1:0] : addr_ff;
        nxt_hreadyout = !accept_rd;
        nxt_hrdata = rd_pend_ff ? rd_view : hrdata_ff;
    end

    // bus flip-flops; hresp stays okay as no access can fail
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff <= '0;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= DATA_ZERO;
            hresp_ff <= 1'b0;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            rd_pend_ff <= nxt_rd_pend;
            addr_ff <= nxt_addr;
            hreadyout_ff <= nxt_hreadyout;
            hrdata_ff <= nxt_hrdata;
            hresp_ff <= 1'b0;
        end
    end

    // transmit configuration next values
    always_comb begin
        nxt_stop = stop_ff;
        nxt_enable = enable_ff;
        nxt_allow = allow_ff;
        nxt_st_flush = 1'b0;
        nxt_dt_flush = 1'b0;
        if (wr_txc) begin
            nxt_allow = hwdata[TXC_ALLOW_BIT];
            nxt_enable = hwdata[TXC_ENABLE_BIT];
            nxt_st_flush = hwdata[TXC_STATUS_FLUSH_BIT];
            nxt_dt_flush = hwdata[TXC_DATA_FLUSH_BIT];
            if (!stop_ff) begin
                nxt_stop = hwdata[TXC_STOP_BIT];
            end
        end
        // halt clears both bits, taking precedence over a host write
        if (halted) begin
            nxt_stop = 1'b0;
            nxt_enable = 1'b0;
        end
        // soft reset completion returns transmit controls to idle
        if (sr_done) begin
            nxt_stop = 1'b0;
            nxt_enable = 1'b0;
            nxt_allow = 1'b0;
        end
    end

    // hardware configuration next values
    always_comb begin
        nxt_port_order = port_order_ff;
        nxt_direct_order = direct_order_ff;
        nxt_mwo = mwo_ff;
        nxt_alloc = alloc_ff;
        nxt_timeout = timeout_ff;
        nxt_strap = strap_ff;
        nxt_strap_pend = strap_pend_ff;
        // reserved allocation codes are kept as written, unclamped;
        // keeping to two through fourteen is left to the host
        if (wr_hwc) begin
            nxt_port_order = hwdata[HWC_PORT_ORDER_BIT];
            nxt_direct_order = hwdata[HWC_DIRECT_ORDER_BIT];
            nxt_mwo = hwdata[HWC_MWO_BIT];
            nxt_alloc = hwdata[HWC_ALLOC_LSB +: HWC_ALLOC_W];
        end
        // a fresh attempt clears the old timeout; a new timeout sets it
        if (sr_start) begin
            nxt_timeout = 1'b0;
        end
        if (sr_timeout) begin
            nxt_timeout = 1'b1;
        end
        // completion restores defaults except the byte order bits
        if (sr_done) begin
            nxt_mwo = 1'b0;
            nxt_alloc = ALLOC_RESET;
            nxt_strap_pend = 1'b1;
        end
        // strap level is caught after reset release, not by the reset
        if (strap_pend_ff) begin
            nxt_strap = crossover_strap;
            nxt_strap_pend = 1'b0;
        end
    end

    // configuration flip-flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stop_ff <= 1'b0;
            enable_ff <= 1'b0;
            allow_ff <= 1'b0;
            st_flush_ff <= 1'b0;
            dt_flush_ff <= 1'b0;
        end else begin
            stop_ff <= nxt_stop;
            enable_ff <= nxt_enable;
            allow_ff <= nxt_allow;
            st_flush_ff <= nxt_st_flush;
            dt_flush_ff <= nxt_dt_flush;
        end
    end

    // hardware configuration flip-flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_order_ff <= 1'b0;
            direct_order_ff <= 1'b0;
            mwo_ff <= 1'b0;
            alloc_ff <= ALLOC_RESET;
            timeout_ff <= 1'b0;
            strap_ff <= 1'b0;
            strap_pend_ff <= 1'b1;
        end else begin
            port_order_ff <= nxt_port_order;
            direct_order_ff <= nxt_direct_order;
            mwo_ff <= nxt_mwo;
            alloc_ff <= nxt_alloc;
            timeout_ff <= nxt_timeout;
            strap_ff <= nxt_strap;
            strap_pend_ff <= nxt_strap_pend;
        end
    end

    // side outputs registered so the core sees clean levels
    // sizes lag an allocation write by one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_start_ok_ff <= 1'b0;
            full_event_ff <= 1'b0;
            sr_active_ff <= 1'b0;
            txd_ff <= '0;
            txs_ff <= '0;
            rxd_ff <= '0;
            rxs_ff <= '0;
        end else begin
            tx_start_ok_ff <= start_gate;
            full_event_ff <= tx_status_full;
            sr_active_ff <= sr_bit;
            txd_ff <= tx_total - TX_STATUS_BYTES;
            txs_ff <= TX_STATUS_BYTES;
            rxd_ff <= rx_total - rx_stat;
            rxs_ff <= rx_stat;
        end
    end

    // soft reset timing and timeout detection
    // a start in the done or timeout cycle is taken, not lost
    thc_software_reset_seq u_software_reset (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(sr_start),
        .phy_clocks_running(phy_clocks_running),
        .busy(sr_busy),
        .done(sr_done),
        .timeout(sr_timeout)
    );

    // only full-word single transfers are expected; size is not checked
    wire unused_size = ^hsize;

    // bus side outputs
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;

    // transmitter side: grant, full event and flush pulses
    assign tx_start_ok = tx_start_ok_ff;
    assign tx_status_full_event = full_event_ff;
    assign tx_status_flush = st_flush_ff;
    assign tx_data_flush = dt_flush_ff;

    // byte order and operating controls
    assign port_byte_order = port_order_ff;
    assign direct_path_byte_order = direct_order_ff;
    assign device_operational = mwo_ff;
    assign soft_reset_active = sr_active_ff;

    // queue memory split toward the queue controllers
    assign tx_data_bytes = txd_ff;
    assign tx_status_bytes = txs_ff;
    assign rx_data_bytes = rxd_ff;
    assign rx_status_bytes = rxs_ff;
endmodule

// ===== src/thc_software_reset_seq.sv
// soft reset sequencer: holds the reset for at least a fixed time, until phy clocks run, and times out
// assumes phy_clocks_running is synchronous to hclk
`timescale 1ns/10ps
module thc_software_reset_seq (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic phy_clocks_running,
    output logic busy,
    output logic done,
    output logic timeout
);
    import thc_pkg::*;

    localparam logic [11:0] HOLD_LAST = 12'(SOFTWARE_RESET_HOLD_CYC - 1);
    localparam logic [11:0] TOUT_LAST = 12'(SOFTWARE_RESET_TIMEOUT_CYC - 1);
    localparam logic [11:0] CNT_ONE = 12'h001;
    localparam logic [11:0] CNT_ZERO = 12'h000;

    thc_sr_state_t state_ff, nxt_state;
    logic [SOFTWARE_RESET_CNT_W-1:0] cnt_ff, nxt_cnt;

    // completion needs running phy clocks once the hold time is reached
    wire hold_met = (cnt_ff >= HOLD_LAST) && phy_clocks_running;
    wire tout_hit = (cnt_ff >= TOUT_LAST);

    // state and counter update
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            THC_SR_IDLE: begin
                nxt_cnt = CNT_ZERO;
                if (start) begin
                    nxt_state = THC_SR_WAIT;
                end
            end
            THC_SR_WAIT: begin
                nxt_cnt = cnt_ff + CNT_ONE;
                if (hold_met) begin
                    nxt_state = THC_SR_DONE;
                end else if (tout_hit) begin
                    nxt_state = THC_SR_TOUT;
                end
            end
            // a start landing in the closing cycle begins a fresh count
            THC_SR_DONE, THC_SR_TOUT: begin
                nxt_cnt = CNT_ZERO;
                nxt_state = start ? THC_SR_WAIT : THC_SR_IDLE;
            end
            default: nxt_state = THC_SR_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= THC_SR_IDLE;
            cnt_ff <= CNT_ZERO;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    assign busy = (state_ff == THC_SR_WAIT);
    assign done = (state_ff == THC_SR_DONE);
    assign timeout = (state_ff == THC_SR_TOUT);
endmodule

// ===== verif/tb.sv
// self-checking bench for the configuration register bank
// assumes the bank answers as its hand-over timing describes
`timescale 1ns/10ps
module tb;
    import thc_pkg::*;
    localparam logic [31:0] TXC = {24'h0, OFF_TRANSMIT_CONFIGURATION};
    localparam logic [31:0] HWC = {24'h0, OFF_HARDWARE_CONFIGURATION};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic tx_status_full = 1'b0;
    logic phy_clocks_running = 1'b1;
    logic crossover_strap = 1'b1;
    logic frame_req = 1'b0;
    logic hreadyout, hresp, tx_frame_busy, tx_start_ok;
    logic tx_status_full_event, tx_status_flush, tx_data_flush;
    logic port_byte_order, direct_path_byte_order;
    logic device_operational, soft_reset_active;
    logic [SIZE_W-1:0] tx_data_bytes, tx_status_bytes;
    logic [SIZE_W-1:0] rx_data_bytes, rx_status_bytes;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic [7:0] frames_sent;
    int mismatches = 0;
    int n_compared = 0;
    always #10 hclk = ~hclk;
    thc_regs thc_regs_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .tx_frame_busy, .tx_status_full,
        .phy_clocks_running, .crossover_strap, .tx_start_ok,
        .tx_status_full_event, .tx_status_flush, .tx_data_flush,
        .port_byte_order, .direct_path_byte_order, .device_operational,
        .soft_reset_active, .tx_data_bytes, .tx_status_bytes,
        .rx_data_bytes, .rx_status_bytes);
    thc_tx_model thc_tx_model_inst (.hclk, .hresetn, .tx_start_ok,
        .frame_req, .tx_frame_busy, .frames_sent);
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string m);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s got %h", $time, m, got);
        end
    endtask
    // level is judged mid-cycle; a wait that runs out ends the run
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (s !== v && n < lim);
        if (s !== v) begin
            mismatches++;
            $display("CHECK FAILED %0t wait ran out", $time);
            summarize();
        end
    endtask
    // single word transfer, each phase held until ready is seen
    task automatic xfer(input logic w, input logic [31:0] a,
            input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        wait_lvl(hreadyout, 1'b1, 40);
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_lvl(hreadyout, 1'b1, 40);
        r = hrdata;
        @(posedge hclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] m,
            input logic [31:0] e);
        xfer(1'b0, a, DATA_ZERO);
        chk(r & m, e, "read");
    endtask
    task automatic sizes(input int k);
        logic [14:0] t;
        logic [14:0] x;
        t = 15'(k * 1024);
        x = TOTAL_BYTES - t;
        chk({17'h0, tx_data_bytes}, {17'h0, t - 15'h0200}, "txd");
        chk({17'h0, tx_status_bytes}, 32'h0000_0200, "txs");
        chk({17'h0, rx_data_bytes}, {17'h0, x - (x >> 4)}, "rxd");
        chk({17'h0, rx_status_bytes}, {17'h0, x >> 4}, "rxs");
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd(TXC, '1, 32'h0000_0000);
        rd(HWC, '1, 32'h0105_0000);
        sizes(5);
        xfer(1'b1, HWC, 32'hf8f8_fffc);
        rd(HWC, '1, 32'h3118_0000);
        chk({29'h0, port_byte_order, direct_path_byte_order,
            device_operational}, 32'h7, "order");
        xfer(1'b1, 32'h0000_007c, '1);
        rd(32'h0000_007c, '1, 32'h0000_0000);
        // every legal allocation, byte orders kept set
        for (int k = 2; k <= 14; k++) begin
            xfer(1'b1, HWC, 32'h3010_0000 | (32'(k) << 16));
            repeat (2) @(negedge hclk);
            sizes(k);
        end
        xfer(1'b1, TXC, 32'hffff_3ffe);
        rd(TXC, '1, 32'h0000_0006);
        tx_status_full <= 1'b1;
        repeat (2) @(negedge hclk);
        chk({30'h0, tx_start_ok, tx_status_full_event},
            32'h3, "go");
        xfer(1'b1, TXC, 32'h0000_c002);
        @(negedge hclk);
        chk({30'h0, tx_status_flush, tx_data_flush},
            32'h3, "fl");
        @(negedge hclk);
        chk({30'h0, tx_status_flush, tx_data_flush},
            32'h0, "fl");
        chk({30'h0, tx_start_ok, tx_status_full_event},
            32'h1, "hold");
        @(posedge hclk);
        tx_status_full <= 1'b0;
        frame_req <= 1'b1;
        wait_lvl(tx_frame_busy, 1'b1, 10);
        @(posedge hclk);
        frame_req <= 1'b0;
        // stop mid-frame: the frame runs out, clearing writes are ignored
        xfer(1'b1, TXC, 32'h0000_0003);
        rd(TXC, '1, 32'h0000_0003);
        xfer(1'b1, TXC, 32'h0000_0002);
        rd(TXC, '1, 32'h0000_0003);
        wait_lvl(tx_frame_busy, 1'b0, 100);
        rd(TXC, '1, 32'h0000_0000);
        chk({24'h0, frames_sent}, 32'h1, "frames");
        // soft reset without phy clocks must time out, then a retry works
        phy_clocks_running <= 1'b0;
        xfer(1'b1, HWC, 32'h3018_0001);
        rd(HWC, 32'h0000_0003, 32'h0000_0001);
        wait_lvl(soft_reset_active, 1'b0, 2200);
        rd(HWC, 32'h3000_0003, 32'h3000_0002);
        phy_clocks_running <= 1'b1;
        crossover_strap <= 1'b0;
        // retry keeps byte orders set so their survival is seen
        xfer(1'b1, HWC, 32'h3018_0001);
        wait_lvl(soft_reset_active, 1'b1, 5);
        wait_lvl(soft_reset_active, 1'b0, 100);
        rd(HWC, '1, 32'h3005_0000);
        rd(TXC, '1, 32'h0000_0000);
        sizes(5);
        summarize();
    end
endmodule
bind thc_regs thc_regs_monitor thc_regs_monitor_inst (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .tx_status_full, .tx_status_full_event, .tx_status_flush,
    .tx_data_flush, .port_byte_order, .direct_path_byte_order,
    .soft_reset_active, .tx_data_bytes, .tx_status_bytes, .rx_data_bytes,
    .rx_status_bytes);

// ===== verif/thc_regs_monitor.sv
// checker for the configuration register bank: bus timing and side outputs
// assumes one ahb-lite master with hready tied back to hreadyout
`timescale 1ns/10ps
module thc_regs_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic tx_status_full,
    input wire logic tx_status_full_event,
    input wire logic tx_status_flush,
    input wire logic tx_data_flush,
    input wire logic port_byte_order,
    input wire logic direct_path_byte_order,
    input wire logic soft_reset_active,
    input wire logic [thc_pkg::SIZE_W-1:0] tx_data_bytes,
    input wire logic [thc_pkg::SIZE_W-1:0] tx_status_bytes,
    input wire logic [thc_pkg::SIZE_W-1:0] rx_data_bytes,
    input wire logic [thc_pkg::SIZE_W-1:0] rx_status_bytes
);
    import thc_pkg::*;
    logic taken;
    logic wr_ph_ff;
    logic tx_ph_ff;
    // remember the address phase so data-phase bits can be judged
    assign taken = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_ff <= 1'b0;
            tx_ph_ff <= 1'b0;
        end else if (hready) begin
            wr_ph_ff <= taken && hwrite;
            tx_ph_ff <= haddr[7:0] == OFF_TRANSMIT_CONFIGURATION;
        end
    end
    // cycles of soft reset activity, saturating at the limit
    localparam logic [11:0] SR_LIMIT = 12'(SOFTWARE_RESET_TIMEOUT_CYC + 10);
    logic [11:0] sr_cyc_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sr_cyc_ff <= 12'h000;
        end else if (!soft_reset_active) begin
            sr_cyc_ff <= 12'h000;
        end else if (sr_cyc_ff != SR_LIMIT) begin
            sr_cyc_ff <= sr_cyc_ff + 12'h001;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_read_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_pulse(p);
        p ##1 !p;
    endsequence
    a_okay_resp: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_read_wait: assert property (taken && !hwrite |=> s_read_wait)
        else $error("read wait state wrong");
    a_status_flush: assert property (
        wr_ph_ff && tx_ph_ff && hwdata[TXC_STATUS_FLUSH_BIT]
        |=> s_pulse(tx_status_flush)) else $error("status flush pulse");
    a_data_flush: assert property (
        wr_ph_ff && tx_ph_ff && hwdata[TXC_DATA_FLUSH_BIT]
        |=> s_pulse(tx_data_flush)) else $error("data flush pulse");
    a_full_event: assert property ($changed(tx_status_full) |=>
        tx_status_full_event == $past(tx_status_full))
        else $error("full event does not follow full");
    a_software_reset_bounded: assert property (soft_reset_active |->
        sr_cyc_ff < SR_LIMIT) else $error("soft reset hangs");
    a_order_kept: assert property (
        soft_reset_active && $past(soft_reset_active) |->
        $stable(port_byte_order) && $stable(direct_path_byte_order))
        else $error("byte order lost in soft reset");
    a_size_sum: assert property ($past(hresetn) |->
        tx_status_bytes == TX_STATUS_BYTES && tx_data_bytes +
        tx_status_bytes + rx_data_bytes + rx_status_bytes == TOTAL_BYTES)
        else $error("queue split does not add up");
    a_rx_split: assert property ($past(hresetn) |->
        rx_status_bytes == (rx_data_bytes + rx_status_bytes) >> 4)
        else $error("rx status share wrong");
endmodule

// ===== verif/thc_tx_model.sv
// transmitter stand-in: sends one frame per request while granted
// assumes the bench raises frame_req just after a rising edge
`timescale 1ns/10ps
module thc_tx_model #(
    parameter int FRAME_CYC = 60
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tx_start_ok,
    input wire logic frame_req,
    output logic tx_frame_busy,
    output logic [7:0] frames_sent
);
    logic [7:0] left_ff;
    // a paused transmitter never starts a frame, a running one finishes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left_ff <= 8'h00;
            frames_sent <= 8'h00;
        end else if (left_ff != 8'h00) begin
            left_ff <= left_ff - 8'h01;
        end else if (frame_req && tx_start_ok) begin
            left_ff <= 8'(FRAME_CYC);
            frames_sent <= frames_sent + 8'h01;
        end
    end
    assign tx_frame_busy = left_ff != 8'h00;
endmodule
